//--- pkg/hsir_defs.vh
`ifndef HSIR_DEFS_VH
`define HSIR_DEFS_VH

// channel count and source selection
`define HSIR_NCH            32
`define HSIR_SRC_BUILTIN    2'h0
`define HSIR_SRC_EXT        2'h1
`define HSIR_SRC_OFF        2'h2
`define HSIR_NBUILTIN       4
`define HSIR_NEXT           16
// action codes
`define HSIR_ACT_CLUTCH     2'h0
`define HSIR_ACT_CNT_EN     2'h1
`define HSIR_ACT_CNT_DIS    2'h2
`define HSIR_ACT_CUR_CHG    2'h3
// compensation limits in microseconds
`define HSIR_COMP_MAX       32'sd5000000
`define HSIR_COMP_MIN       (-32'sd5000000)
// timing
`define HSIR_CLK_NS         100
`define HSIR_US_NS          1000
`define HSIR_US_CYC         (`HSIR_US_NS / `HSIR_CLK_NS)
`define HSIR_CYC_US_DEF     888
`define HSIR_ACC_BUILTIN_US 9'h01e
`define HSIR_ACC_RT04_US    9'h045
`define HSIR_ACC_RT06_US    9'h085
`define HSIR_ACC_RT10_US    9'h105
// register offsets
`define HSIR_REG_CTRL       12'h000
`define HSIR_REG_VALID      12'h004
`define HSIR_REG_STATUS     12'h008
`define HSIR_REG_EDGE       12'h00c
`define HSIR_REG_IRQ_ST     12'h010
`define HSIR_REG_IRQ_EN     12'h014
`define HSIR_REG_IRQ_CLR    12'h018
`define HSIR_REG_VALUSE     12'h01c
`define HSIR_REG_BIN        12'h020
`define HSIR_REG_CYCLE      12'h024
`define HSIR_REG_SEL        12'h028
`define HSIR_REG_CHCFG      12'h02c
`define HSIR_REG_COMP       12'h030
`define HSIR_REG_STAMP      12'h034
`define HSIR_REG_ACC        12'h038
// channel config field positions
`define HSIR_CF_SRC_LO      0
`define HSIR_CF_IDX_LO      2
`define HSIR_CF_ACT_LO      6
`define HSIR_CF_TRAIL       8
`define HSIR_CF_MAINB       9
`define HSIR_CF_RT_LO       10
// ctrl bits
`define HSIR_CTRL_SYNC      0
`define HSIR_CTRL_ENCREQ    1

`endif

//--- verilog/hsir_sync.v
`timescale 1ns/100ps
`default_nettype none

// two flop synchroniser for a bus of pins
module hsir_sync #(
    parameter W = 20
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] meta;
    reg [W-1:0] sync;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= {W{1'b0}};
            sync <= {W{1'b0}};
        end else begin
            meta <= d;
            sync <= meta;
        end
    end

    assign q = sync;

endmodule

`default_nettype wire

//--- verilog/hsir_capture.v
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "hsir_defs.vh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// - up to 32 channels, each with source, compensation, valid flag, status.
// - accepted edge fires clutch or encoder counter enable/disable/change; of edges accepted in one cycle only the lowest channel fires.
// - signed microsecond compensation shifts the effective event time.
// - compensation saturates at -5000000 and 5000000 microseconds.
// - status bit shows raw input, no compensation applied.
// - compensation word re-read each operation cycle, even aligned.
// - edges on a channel that uses a valid flag accepted only while the flag is set.
// - channel without a valid flag is always enabled.
// - status bits refreshed every operation cycle regardless of flag.
// - edge while sync off or encoder request off clears valid flag.
// - four built-in inputs, 30 microsecond accuracy.
// - external accuracy 69, 133, 261 us for 0.4, 0.6, 1.0 ms.
// - active edge per channel selectable leading or trailing.
// - only main-base external modules qualify as sources.
// - upper twenty-eight bits of built-in input area read as zero.
module hsir_capture #(
    parameter CYCLE_US = `HSIR_CYC_US_DEF
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [3:0]  builtin_digital_input,
    input  wire [15:0] proximity_change_input,
    input  wire        sync_control_active_status,
    input  wire        encoder_axis_control_request,
    output reg         clutch_toggle,
    output reg         counter_enable,
    output reg         counter_disable,
    output reg         current_value_change,
    output reg  [4:0]  event_channel,
    output reg  [31:0] event_time_us,
    output reg         cycle_start,
    output wire        irq
);

    reg  [31:0] ctrl;
    reg  [31:0] valid_flag;
    reg  [31:0] valid_used;
    reg  [31:0] status;
    reg  [31:0] irq_st;
    reg  [31:0] irq_en;
    reg  [4:0]  sel;
    reg  [11:0] chcfg [0:31];
    reg  [31:0] comp_word [0:31];
    reg  [31:0] comp_cur [0:31];
    reg  [31:0] stamp [0:31];
    reg  [3:0]  us_div;
    reg  [31:0] us_cnt;
    reg  [19:0] prev_in;
    reg  [31:0] next_status;
    reg  [31:0] raw;
    reg  [31:0] hit;
    reg  [31:0] accept;
    reg  [31:0] drop;
    reg  [4:0]  win_ch;
    reg         win_any;
    wire [19:0] pins_s;
    wire        wr;
    wire        rd_ok;
    wire        us_tick;
    wire        cyc_end;
    integer     i;
    integer     j;

    ///////////////////////////////////////////////////////////////////////////
    // saturation and accuracy
    // clamp compensation
    function [31:0] sat_comp;
        input [31:0] v;
        begin
            if ($signed(v) > `HSIR_COMP_MAX)
                sat_comp = `HSIR_COMP_MAX;
            else if ($signed(v) < `HSIR_COMP_MIN)
                sat_comp = `HSIR_COMP_MIN;
            else
                sat_comp = v;
        end
    endfunction

    function [8:0] acc_us;
        input [11:0] cf;
        begin
            if (cf[1:0] == `HSIR_SRC_BUILTIN)
                acc_us = `HSIR_ACC_BUILTIN_US;
            else if (cf[11:10] == 2'h0)
                acc_us = `HSIR_ACC_RT04_US;
            else if (cf[11:10] == 2'h1)
                acc_us = `HSIR_ACC_RT06_US;
            else
                acc_us = `HSIR_ACC_RT10_US;
        end
    endfunction

    function edge_hit;
        input lvl;
        input prv;
        input trail;
        begin
            edge_hit = trail ? (prv & ~lvl) : (~prv & lvl);
        end
    endfunction

    // external pins sit above the built-in ones
    function [4:0] pin_sel;
        input [11:0] cf;
        begin
            if (cf[1:0] == `HSIR_SRC_EXT)
                pin_sel = 5'h04 + {1'b0, cf[5:2]};
            else
                pin_sel = {3'h0, cf[3:2]};
        end
    endfunction

    ///////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    hsir_sync #(
        .W (20)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({proximity_change_input, builtin_digital_input}),
        .q       (pins_s)
    );

    ///////////////////////////////////////////////////////////////////////////
    // microsecond and cycle timebase
    assign us_tick = (us_div == (`HSIR_US_CYC - 1));
    assign cyc_end = us_tick && (us_cnt == (CYCLE_US - 1));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            us_div      <= 4'h0;
            us_cnt      <= 32'h0;
            cycle_start <= 1'b0;
        end else begin
            cycle_start <= cyc_end;
            if (us_tick) begin
                us_div <= 4'h0;
                us_cnt <= cyc_end ? 32'h0 : us_cnt + 32'h1;
            end else begin
                us_div <= us_div + 4'h1;
            end
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // per channel edge detect and qualification
    always @* begin
        raw     = 32'h0;
        hit     = 32'h0;
        accept  = 32'h0;
        drop    = 32'h0;
        win_any = 1'b0;
        win_ch  = 5'h00;
        for (i = 0; i < `HSIR_NCH; i = i + 1) begin
            case (chcfg[i][1:0])
                `HSIR_SRC_BUILTIN: begin
                    raw[i] = pins_s[pin_sel(chcfg[i])];
                    hit[i] = edge_hit(raw[i], prev_in[pin_sel(chcfg[i])],
                                      chcfg[i][`HSIR_CF_TRAIL]);
                end
                `HSIR_SRC_EXT: begin
                    raw[i] = pins_s[pin_sel(chcfg[i])];
                    hit[i] = edge_hit(raw[i], prev_in[pin_sel(chcfg[i])],
                                      chcfg[i][`HSIR_CF_TRAIL]);
                    hit[i] = hit[i] & chcfg[i][`HSIR_CF_MAINB];
                end
                default: begin
                    raw[i] = 1'b0;
                    hit[i] = 1'b0;
                end
            endcase
            if (hit[i] && (!sync_control_active_status ||
                           !encoder_axis_control_request))
                drop[i] = 1'b1;
            // flag gate, absent flag is on
            else if (hit[i] && (valid_flag[i] || !valid_used[i]))
                accept[i] = 1'b1;
            // lowest accepting channel drives the outputs
            if (accept[i] && !win_any) begin
                win_any = 1'b1;
                win_ch  = i[4:0];
            end
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // status refresh at cycle end
    always @* begin
        next_status = status;
        if (cyc_end)
            next_status = raw;
    end

    ///////////////////////////////////////////////////////////////////////////
    // event outputs, one channel per cycle by priority
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clutch_toggle        <= 1'b0;
            counter_enable       <= 1'b0;
            counter_disable      <= 1'b0;
            current_value_change <= 1'b0;
            event_channel        <= 5'h0;
            event_time_us        <= 32'h0;
            prev_in              <= 20'h0;
            status               <= 32'h0;
        end else begin
            prev_in              <= pins_s;
            clutch_toggle        <= 1'b0;
            counter_enable       <= 1'b0;
            counter_disable      <= 1'b0;
            current_value_change <= 1'b0;
            status <= next_status;
            if (win_any) begin
                event_channel <= win_ch;
                event_time_us <= us_cnt - comp_cur[win_ch];
                case (chcfg[win_ch][7:6])
                    `HSIR_ACT_CLUTCH:  clutch_toggle <= 1'b1;
                    `HSIR_ACT_CNT_EN:  counter_enable <= 1'b1;
                    `HSIR_ACT_CNT_DIS: counter_disable <= 1'b1;
                    default:           current_value_change <= 1'b1;
                endcase
            end
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // channel arrays
    // 32 channel slots
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (j = 0; j < `HSIR_NCH; j = j + 1) begin
                chcfg[j]     <= {10'h0, `HSIR_SRC_OFF};
                comp_word[j] <= 32'h0;
                comp_cur[j]  <= 32'h0;
                stamp[j]     <= 32'h0;
            end
        end else begin
            for (j = 0; j < `HSIR_NCH; j = j + 1) begin
                if (cyc_end)
                    comp_cur[j] <= sat_comp(comp_word[j]);
                if (accept[j])
                    stamp[j] <= us_cnt;
            end
            if (wr && paddr == `HSIR_REG_CHCFG)
                chcfg[sel] <= pwdata[11:0];
            if (wr && paddr == `HSIR_REG_COMP)
                comp_word[sel] <= pwdata;
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // apb registers
    assign wr      = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign rd_ok   = (paddr[1:0] == 2'h0) && (paddr <= `HSIR_REG_ACC);
    assign pslverr = psel && penable && !rd_ok;
    assign irq     = |(irq_st & irq_en);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl       <= 32'h0;
            valid_flag <= 32'h0;
            valid_used <= 32'h0;
            irq_st     <= 32'h0;
            irq_en     <= 32'h0;
            sel        <= 5'h0;
        end else begin
            if (wr && paddr == `HSIR_REG_CTRL)
                ctrl <= pwdata;
            if (wr && paddr == `HSIR_REG_VALUSE)
                valid_used <= pwdata;
            if (wr && paddr == `HSIR_REG_SEL)
                sel <= pwdata[4:0];
            if (wr && paddr == `HSIR_REG_IRQ_EN)
                irq_en <= pwdata;
            if (wr && paddr == `HSIR_REG_VALID)
                valid_flag <= pwdata & ~drop;
            else
                valid_flag <= valid_flag & ~drop;
            // set wins over clear
            if (wr && paddr == `HSIR_REG_IRQ_CLR)
                irq_st <= (irq_st & ~pwdata) | accept;
            else
                irq_st <= irq_st | accept;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `HSIR_REG_CTRL:   prdata <= ctrl;
                `HSIR_REG_VALID:  prdata <= valid_flag;
                `HSIR_REG_STATUS: prdata <= status;
                `HSIR_REG_EDGE:   prdata <= accept;
                `HSIR_REG_IRQ_ST: prdata <= irq_st;
                `HSIR_REG_IRQ_EN: prdata <= irq_en;
                `HSIR_REG_VALUSE: prdata <= valid_used;
                `HSIR_REG_BIN:    prdata <= {28'h0, pins_s[3:0]};
                `HSIR_REG_CYCLE:  prdata <= us_cnt;
                `HSIR_REG_SEL:    prdata <= {27'h0, sel};
                `HSIR_REG_CHCFG:  prdata <= {20'h0, chcfg[sel]};
                `HSIR_REG_COMP:   prdata <= comp_cur[sel];
                `HSIR_REG_STAMP:  prdata <= stamp[sel];
                `HSIR_REG_ACC:    prdata <= {23'h0, acc_us(chcfg[sel])};
                default:          prdata <= 32'h0;
            endcase
        end
    end

endmodule

`default_nettype wire

//--- verif/hsir_chk.sv
`timescale 1ns/100ps
`default_nettype none
module hsir_chk #(
    parameter CYCLE_US = 888
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        clutch_toggle,
    input wire logic        counter_enable,
    input wire logic        counter_disable,
    input wire logic        current_value_change,
    input wire logic [4:0]  event_channel,
    input wire logic        cycle_start
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [3:0]   act;
    logic [31:0] gap;
    logic        seen;
    assign act = {current_value_change, counter_disable,
                  counter_enable, clutch_toggle};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= 32'h0;
            seen <= 1'b0;
        end else if (cycle_start) begin
            gap <= 32'h0;
            seen <= 1'b1;
        end else begin
            gap <= gap + 32'h1;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_acc;
        psel && penable;
    endsequence
    AST_RDY: assert property (psel |-> pready)
        else $error("pready low");
    AST_ERR_HI: assert property (s_acc and paddr > 12'h038 |-> pslverr)
        else $error("no error on unmapped");
    AST_ERR_OK: assert property (s_acc and paddr <= 12'h038
        and paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped");
    AST_ERR_SETUP: assert property (s_setup |-> !pslverr)
        else $error("error in setup");
    AST_ONE_ACT: assert property ($onehot0(act))
        else $error("several actions");
    AST_EVT_HOLD: assert property (act == 4'h0 |-> $stable(event_channel))
        else $error("event changed without action");
    AST_CYC_PULSE: assert property (cycle_start |=> !cycle_start)
        else $error("cycle pulse too long");
    AST_CYC_PER: assert property (cycle_start && seen
        |-> gap == CYCLE_US * 10 - 1)
        else $error("cycle period wrong");
    AST_CYC_MAX: assert property (gap <= CYCLE_US * 10)
        else $error("cycle pulse missing");
endmodule
bind hsir_capture hsir_chk #(.CYCLE_US(CYCLE_US)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .clutch_toggle(clutch_toggle), .counter_enable(counter_enable),
    .counter_disable(counter_disable),
    .current_value_change(current_value_change),
    .event_channel(event_channel), .cycle_start(cycle_start));
`default_nettype wire

//--- verif/hsir_sensor.sv
`timescale 1ns/100ps
`default_nettype none
module hsir_sensor (
    input  wire logic        pclk,
    output var  logic [3:0]  bin,
    output var  logic [15:0] prox,
    output var  logic        sync_on,
    output var  logic        enc_req
);
    initial begin
        bin = 4'h0;
        prox = 16'h0;
        sync_on = 1'b1;
        enc_req = 1'b1;
    end
    task automatic set(input logic [3:0] b, input logic s);
        @(posedge pclk);
        bin <= b;
        sync_on <= s;
    endtask
    task automatic set_ext(input logic [15:0] p, input logic e);
        @(posedge pclk);
        prox <= p;
        enc_req <= e;
    endtask
endmodule
`default_nettype wire

//--- verif/hsir_capture_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "hsir_defs.vh"
module hsir_capture_tb;
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, q, a, et;
    logic pready, pslverr, serr, irq, cs;
    logic ct, ce, cd, cc;
    logic [3:0]  bin, v;
    logic [15:0] prox;
    logic sync_on, enc_req;
    logic [4:0]  ech;
    int bad_count = 0, num_checks = 0;
    always #50 pclk = ~pclk;
    hsir_sensor sen_u (.pclk(pclk), .bin(bin), .prox(prox),
        .sync_on(sync_on), .enc_req(enc_req));
    hsir_capture #(.CYCLE_US(4)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .builtin_digital_input(bin),
        .proximity_change_input(prox), .sync_control_active_status(sync_on),
        .encoder_axis_control_request(enc_req), .clutch_toggle(ct),
        .counter_enable(ce), .counter_disable(cd),
        .current_value_change(cc), .event_channel(ech),
        .event_time_us(et), .cycle_start(cs), .irq(irq));
    task automatic end_sim;
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            end_sim;
        end
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wact;
        int n;
        v = 4'h0;
        for (n = 0; n < 30 && v == 4'h0; n++) begin
            @(negedge pclk);
            v = {cc, cd, ce, ct};
        end
    endtask
    initial begin
        #6000000;
        bad_count++;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h03c, 32'h0);
        chk("unmapped err", serr, 1'b1);
        chk("unmapped data", q, 32'h0);
        apb(0, `HSIR_REG_VALID, 32'h0);
        chk("valid reset", q, 32'h0);
        apb(1, `HSIR_REG_SEL, 32'h0);
        apb(1, `HSIR_REG_VALUSE, 32'h1);
        apb(1, `HSIR_REG_IRQ_EN, 32'h1);
        for (a = 0; a < 4; a++) begin
            apb(1, `HSIR_REG_CHCFG, a << 6);
            apb(1, `HSIR_REG_VALID, 32'h1);
            sen_u.set(4'h1, 1'b1);
            wact;
            chk("action", v, 4'h1 << a);
            chk("channel", ech, 5'h0);
            sen_u.set(4'h0, 1'b1);
        end
        @(negedge pclk);
        chk("irq set", irq, 1'b1);
        apb(1, `HSIR_REG_IRQ_CLR, 32'h1);
        @(negedge pclk);
        chk("irq clr", irq, 1'b0);
        apb(1, `HSIR_REG_VALID, 32'h0);
        sen_u.set(4'h1, 1'b1);
        wact;
        chk("flag off", v, 4'h0);
        apb(1, `HSIR_REG_VALUSE, 32'h0);
        apb(1, `HSIR_REG_COMP, 32'h005b8d80);
        sen_u.set(4'h0, 1'b1);
        repeat (90) @(posedge pclk);
        apb(0, `HSIR_REG_COMP, 32'h0);
        chk("comp hi", q, 32'h004c4b40);
        sen_u.set(4'h1, 1'b1);
        wact;
        chk("no flag", v, 4'h8);
        chk("time", (et + 32'h004c4b40) < 32'h4, 1'b1);
        repeat (90) @(posedge pclk);
        apb(0, `HSIR_REG_STATUS, 32'h0);
        chk("status", q & 32'h1, 32'h1);
        apb(1, `HSIR_REG_COMP, 32'hffa47280);
        repeat (90) @(posedge pclk);
        apb(0, `HSIR_REG_COMP, 32'h0);
        chk("comp lo", q, 32'hffb3b4c0);
        apb(1, `HSIR_REG_CHCFG, 32'h000001c0);
        sen_u.set(4'h0, 1'b1);
        wact;
        chk("trailing", v, 4'h8);
        sen_u.set(4'hf, 1'b1);
        sen_u.set_ext(16'hffff, 1'b1);
        repeat (90) @(posedge pclk);
        apb(0, `HSIR_REG_BIN, 32'h0);
        chk("pin area", q, 32'hf);
        apb(1, `HSIR_REG_VALUSE, 32'h1);
        apb(1, `HSIR_REG_VALID, 32'h1);
        sen_u.set(4'h0, 1'b0);
        repeat (10) @(posedge pclk);
        apb(0, `HSIR_REG_VALID, 32'h0);
        chk("flag drop", q & 32'h1, 32'h0);
        apb(0, `HSIR_REG_ACC, 32'h0);
        chk("acc builtin", q, 32'h1e);
        apb(1, `HSIR_REG_SEL, 32'h1);
        apb(1, `HSIR_REG_CHCFG, 32'h009);
        sen_u.set(4'h0, 1'b1);
        sen_u.set_ext(16'h0, 1'b1);
        repeat (5) @(posedge pclk);
        apb(0, `HSIR_REG_ACC, 32'h0);
        chk("acc 0.4", q, 32'h45);
        sen_u.set_ext(16'h4, 1'b1);
        wact;
        chk("ext base", v, 4'h0);
        sen_u.set_ext(16'h0, 1'b1);
        apb(1, `HSIR_REG_CHCFG, 32'ha09);
        apb(0, `HSIR_REG_ACC, 32'h0);
        chk("acc 1.0", q, 32'h105);
        sen_u.set_ext(16'h4, 1'b1);
        wact;
        chk("ext main", v, 4'h1);
        chk("ext channel", ech, 5'h1);
        apb(0, `HSIR_REG_STAMP, 32'h0);
        chk("stamp", q < 32'h4, 1'b1);
        apb(1, `HSIR_REG_VALUSE, 32'h2);
        apb(1, `HSIR_REG_VALID, 32'h2);
        sen_u.set_ext(16'h0, 1'b1);
        repeat (5) @(posedge pclk);
        sen_u.set_ext(16'h4, 1'b0);
        wact;
        chk("enc off", v, 4'h0);
        apb(0, `HSIR_REG_VALID, 32'h0);
        chk("enc drop", q & 32'h2, 32'h0);
        end_sim;
    end
endmodule
`default_nettype wire
